// [rtl/ppaux_bank.sv]
// Purpose: per-port auxiliary register bank with indirect MMD access
// Assumes: event and link inputs are levels from the PHY core, async to pclk
// Notes: MMD storage lives outside; this block issues one-cycle access strobes
`timescale 1ns/1ps
`include "ppaux_defines.svh"
//
// Summary of operation
// - Mode 00: data register accesses read or write the stored MMD register address.
// - Mode 01: data register accesses MMD data; stored address unchanged.
// - Mode 10: data access, address advances after every read and write.
// - Mode 11: data access, address advances after writes only.
// - Setup bits 4:0 select the target MMD, reset zero.
// - Data register returns or updates data at the stored address in modes 01 to 11, reset zero.
// - Loopback bit 8 set sends received line data back out the port.
// - Sixteen-bit counter of frames with symbol errors, cleared on read.
// - Jabber enable bit 15, latched status bit 7.
// - Receive error enable bit 14, latched status bit 6.
// - Page received enable bit 13, latched status bit 5.
// - Parallel detect fault enable bit 12, latched status bit 4.
// - Link partner acknowledge enable bit 11, latched status bit 3.
// - Link down enable bit 10, latched status bit 2.
// - Remote fault enable bit 9, latched status bit 1.
// - Link up enable bit 8, latched status bit 0.
// - Status bits read-only, set on event, clear on read, reset zero.
// - Page received status latches high until read.
module ppaux_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_up_100,
   input wire logic symerr_frame,
   input wire logic [7:0] event_in,
   output logic loopback_en,
   output logic [4:0] mmd_dev,
   output logic [15:0] mmd_reg_addr,
   output logic [15:0] mmd_wdata,
   output logic mmd_wr,
   output logic mmd_rd,
   input wire logic [15:0] mmd_rdata,
   output logic port_irq
);
   import ppaux_pkg::*;

   ppaux_state_type cur_reg, nxt_next;
   logic access;
   logic [`PPAUX_ADDR_W-1:0] idx;
   logic mapped;
   logic inc;
   logic [15:0] rd_val;
   logic [7:0] ev_rise;
   logic frm_rise;
   ppaux_mode_type mode;

   assign access = psel & penable;
   assign idx = paddr[11:2];
   assign mode = ppaux_mode_type'(cur_reg.setup_reg[`PPAUX_MODE_MSB:`PPAUX_MODE_LSB]);
   // Edge detect sits after the third event stage and the second frame stage
   assign ev_rise = cur_reg.ev_sync2_reg & ~cur_reg.ev_prev_reg;
   assign frm_rise = cur_reg.frm_sync_reg[1] & ~cur_reg.frm_prev_reg;

   always_comb begin
      mapped = 1'b1;
      rd_val = 16'h0000;
      case (idx)
         `PPAUX_ADDR_W'(`PPAUX_IDX_SETUP): rd_val = cur_reg.setup_reg;
         `PPAUX_ADDR_W'(`PPAUX_IDX_DATA): begin
            if (mode == PPAUX_MODE_REG) begin
               rd_val = cur_reg.mmd_addr_reg;
            end else begin
               rd_val = mmd_rdata;
            end
         end
         `PPAUX_ADDR_W'(`PPAUX_IDX_LOOP): rd_val = cur_reg.loop_reg;
         `PPAUX_ADDR_W'(`PPAUX_IDX_LINK): rd_val = {15'h0000, cur_reg.link_sync_reg[1]};
         `PPAUX_ADDR_W'(`PPAUX_IDX_SYMERR): rd_val = cur_reg.symerr_reg;
         `PPAUX_ADDR_W'(`PPAUX_IDX_IRQ): rd_val = {cur_reg.irq_en_reg, cur_reg.irq_sts_reg};
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      nxt_next = cur_reg;
      inc = 1'b0;
      nxt_next.mmd_wr_reg = 1'b0;
      nxt_next.mmd_rd_reg = 1'b0;
      nxt_next.link_sync_reg = {cur_reg.link_sync_reg[0], link_up_100};
      nxt_next.frm_sync_reg = {cur_reg.frm_sync_reg[0], symerr_frame};
      nxt_next.ev_sync1_reg = {cur_reg.ev_sync1_reg[7:0], event_in};
      nxt_next.ev_sync2_reg = cur_reg.ev_sync1_reg[15:8];
      nxt_next.ev_prev_reg = cur_reg.ev_sync2_reg;
      nxt_next.frm_prev_reg = cur_reg.frm_sync_reg[1];
      if (access) begin
         nxt_next.prdata_reg = {16'h0000, rd_val};
      end
      // Clear on read first, so a same-cycle event below still sets
      if (access && !pwrite && idx == `PPAUX_ADDR_W'(`PPAUX_IDX_IRQ)) begin
         nxt_next.irq_sts_reg = 8'h00;
      end
      if (access && !pwrite && idx == `PPAUX_ADDR_W'(`PPAUX_IDX_SYMERR)) begin
         nxt_next.symerr_reg = `PPAUX_CNT_RST;
      end
      if (access && pwrite && pstrb[0] && pstrb[1]) begin
         case (idx)
            `PPAUX_ADDR_W'(`PPAUX_IDX_SETUP): nxt_next.setup_reg = pwdata[15:0];
            `PPAUX_ADDR_W'(`PPAUX_IDX_LOOP): nxt_next.loop_reg = {pwdata[15:2], 2'b00};
            `PPAUX_ADDR_W'(`PPAUX_IDX_IRQ): nxt_next.irq_en_reg = pwdata[15:8];
            `PPAUX_ADDR_W'(`PPAUX_IDX_DATA): begin
               if (mode == PPAUX_MODE_REG) begin
                  nxt_next.mmd_addr_reg = pwdata[15:0];
               end else begin
                  nxt_next.mmd_wr_reg = 1'b1;
                  nxt_next.mmd_wdata_reg = pwdata[15:0];
                  inc = (mode != PPAUX_MODE_DATA);
               end
            end
            default: ;
         endcase
      end
      if (access && !pwrite && idx == `PPAUX_ADDR_W'(`PPAUX_IDX_DATA)
          && mode != PPAUX_MODE_REG) begin
         nxt_next.mmd_rd_reg = 1'b1;
         inc = (mode == PPAUX_MODE_INC_RW);
      end
      // Strobes carry the address used by this access; advance afterwards
      if (nxt_next.mmd_wr_reg || nxt_next.mmd_rd_reg) begin
         nxt_next.mmd_dev_reg = cur_reg.setup_reg[`PPAUX_DEVAD_MSB:0];
         nxt_next.mmd_reg_addr_reg = cur_reg.mmd_addr_reg;
      end
      if (inc) begin
         nxt_next.mmd_addr_reg = cur_reg.mmd_addr_reg + 16'h0001;
      end
      // Counter saturates rather than wrapping to hide overflow
      if (frm_rise && nxt_next.symerr_reg != 16'hFFFF) begin
         nxt_next.symerr_reg = nxt_next.symerr_reg + 16'h0001;
      end
      nxt_next.irq_sts_reg = nxt_next.irq_sts_reg | ev_rise;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_reg <= '0;
         cur_reg.setup_reg <= `PPAUX_SETUP_RST;
         cur_reg.mmd_addr_reg <= `PPAUX_DATA_RST;
         cur_reg.loop_reg <= `PPAUX_LOOP_RST;
         cur_reg.symerr_reg <= `PPAUX_CNT_RST;
         cur_reg.irq_en_reg <= `PPAUX_EN_RST;
      end else begin
         cur_reg <= nxt_next;
      end
   end

   assign prdata = cur_reg.prdata_reg;
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign loopback_en = cur_reg.loop_reg[`PPAUX_LOOP_BIT];
   assign mmd_dev = cur_reg.mmd_dev_reg;
   assign mmd_reg_addr = cur_reg.mmd_reg_addr_reg;
   assign mmd_wdata = cur_reg.mmd_wdata_reg;
   assign mmd_wr = cur_reg.mmd_wr_reg;
   assign mmd_rd = cur_reg.mmd_rd_reg;
   assign port_irq = |(cur_reg.irq_sts_reg & cur_reg.irq_en_reg);
endmodule

// [rtl/ppaux_defines.svh]
// Purpose: offsets, field positions, reset values of the port auxiliary bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: register indices are word numbers; the byte address is four times the index
`ifndef PPAUX_DEFINES_SVH
`define PPAUX_DEFINES_SVH
`define PPAUX_IDX_SETUP 8'h1A
`define PPAUX_IDX_DATA 8'h1C
`define PPAUX_IDX_LOOP 8'h22
`define PPAUX_IDX_LINK 8'h26
`define PPAUX_IDX_SYMERR 8'h2A
`define PPAUX_IDX_IRQ 8'h36
`define PPAUX_MODE_MSB 15
`define PPAUX_MODE_LSB 14
`define PPAUX_DEVAD_MSB 4
`define PPAUX_LOOP_BIT 8
`define PPAUX_LOOP_RST 16'h00F4
`define PPAUX_SETUP_RST 16'h0000
`define PPAUX_DATA_RST 16'h0000
`define PPAUX_CNT_RST 16'h0000
`define PPAUX_EN_RST 8'h00
`define PPAUX_ADDR_W 10
`endif

// [rtl/ppaux_pkg.sv]
// Purpose: types of the port auxiliary bank
// Assumes: nothing
// Notes: mode encoding follows the setup register field
package ppaux_pkg;
   typedef enum logic [1:0] {
      PPAUX_MODE_REG = 2'h0,
      PPAUX_MODE_DATA = 2'h1,
      PPAUX_MODE_INC_RW = 2'h2,
      PPAUX_MODE_INC_WR = 2'h3
   } ppaux_mode_type;
   typedef struct packed {
      logic [15:0] setup_reg;
      logic [15:0] mmd_addr_reg;
      logic [15:0] loop_reg;
      logic [15:0] symerr_reg;
      logic [7:0] irq_en_reg;
      logic [7:0] irq_sts_reg;
      logic [31:0] prdata_reg;
      logic mmd_wr_reg;
      logic mmd_rd_reg;
      logic [15:0] mmd_wdata_reg;
      logic [4:0] mmd_dev_reg;
      logic [15:0] mmd_reg_addr_reg;
      logic [1:0] link_sync_reg;
      logic [1:0] frm_sync_reg;
      logic [15:0] ev_sync1_reg;
      logic [7:0] ev_sync2_reg;
      logic [7:0] ev_prev_reg;
      logic frm_prev_reg;
   } ppaux_state_type;
endpackage

// [sim/ppaux_asserts.sv]
// Purpose: port checks for ppaux_bank
// Assumes: zero wait APB; MMD strobes one cycle after the access edge
// Notes: strobe side outputs are registered at the access edge, so causes sit one cycle back
`timescale 1ns/1ps
module ppaux_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic loopback_en,
   input wire logic [4:0] mmd_dev,
   input wire logic [15:0] mmd_reg_addr,
   input wire logic [15:0] mmd_wdata,
   input wire logic mmd_wr,
   input wire logic mmd_rd
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel & penable;
   wire wok = acc & pwrite & (pstrb[1:0] == 2'h3);
   wire [9:0] ix = paddr[11:2];
   a_upper_zero: assert property (prdata[31:16] == 16'h0000) else $error("prdata high half");
   a_wr_cause: assert property (mmd_wr |-> $past(wok && ix == 10'h01C)) else $error("stray wr");
   a_wr_data: assert property (mmd_wr |-> mmd_wdata == $past(pwdata[15:0])) else $error("wdata");
   a_rd_cause: assert property (mmd_rd |-> $past(acc && !pwrite && ix == 10'h01C)) else $error("rd");
   a_loop_write: assert property (wok && ix == 10'h022 |=> loopback_en == $past(pwdata[8]))
      else $error("loop write");
   a_loop_stable: assert property (!$stable(loopback_en) |-> $past(wok && ix == 10'h022))
      else $error("loop moved");
   a_dev_stable: assert property (!$stable(mmd_dev) |-> $past(acc && ix == 10'h01C))
      else $error("dev moved");
   a_addr_cause: assert property (!$stable(mmd_reg_addr) |-> $past(acc && ix == 10'h01C))
      else $error("addr moved");
endmodule
bind ppaux_bank ppaux_asserts u_ppaux_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .loopback_en, .mmd_dev, .mmd_reg_addr, .mmd_wdata, .mmd_wr, .mmd_rd);

// [sim/ppaux_bank_tb.sv]
// Purpose: self-checking bench for ppaux_bank
// Assumes: zero wait APB, read data valid the cycle after the access edge
// Notes: event pulses are long so the synchronisers never miss an edge
`timescale 1ns/1ps
module ppaux_bank_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic link_up_100 = 0, symerr_frame = 0, rd_v = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [3:0] pstrb = 0;
   logic [7:0] event_in = 0;
   logic [15:0] mmd_rdata = 0, mmd_reg_addr, mmd_wdata, a, d;
   logic [4:0] mmd_dev;
   logic pready, pslverr, loopback_en, mmd_wr, mmd_rd, port_irq, slv;
   logic [31:0] q[$];
   int error_cnt = 0, checked = 0, cyc = 0, n;
   ppaux_bank u_ppaux_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .link_up_100, .symerr_frame, .event_in, .loopback_en, .mmd_dev,
      .mmd_reg_addr, .mmd_wdata, .mmd_wr, .mmd_rd, .mmd_rdata, .port_irq);
   initial forever #25 pclk = ~pclk;
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task close_out;
      $display("errors=%0d checks=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         close_out;
      end
   end
   // Read data is registered, so it is judged one edge after completion
   always @(posedge pclk) if (rd_v) cmp(prdata, q.pop_front());
   task wt(input int k);
      repeat (k) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] dt, input logic [3:0] st);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dt;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      slv = pslverr;
      psel <= 0;
      penable <= 0;
      rd_v <= !w;
      @(posedge pclk);
      rd_v <= 0;
   endtask
   task rd(input logic [11:0] ad, input logic [31:0] e);
      q.push_back(e);
      apb(0, ad, 0, 0);
   endtask
   initial begin
      void'($urandom(32470));
      a = $urandom;
      d = $urandom;
      repeat (10) @(posedge pclk);
      presetn <= 1;
      rd(12'h068, 0);
      rd(12'h070, 0);
      rd(12'h088, 32'h00F4);
      rd(12'h0A8, 0);
      rd(12'h0D8, 0);
      cmp(slv, 0);
      cmp(loopback_en, 0);
      rd(12'h000, 0);
      cmp(slv, 1);
      apb(1, 12'h070, a, 4'hF);
      rd(12'h070, a);
      for (int m = 1; m < 4; m++) begin
         apb(1, 12'h068, {m[1:0], 9'h000, d[4:0]}, 4'hF);
         apb(1, 12'h070, d, 4'hF);
         // Strobes carry the address used by the access, before any advance
         cmp(mmd_dev, d[4:0]);
         cmp(mmd_wdata, d);
         cmp(mmd_reg_addr, a);
         a = a + (m > 1);
         mmd_rdata <= d ^ 16'h5A5A;
         rd(12'h070, d ^ 16'h5A5A);
         cmp(mmd_reg_addr, a);
         a = a + (m == 2);
      end
      apb(1, 12'h068, 0, 4'hF);
      rd(12'h070, a);
      apb(1, 12'h088, 32'h0100, 4'h0);
      cmp(loopback_en, 0);
      apb(1, 12'h088, 32'hFFFF, 4'hF);
      cmp(loopback_en, 1);
      rd(12'h088, 32'hFFFC);
      link_up_100 <= 1;
      n = $urandom_range(5, 1);
      repeat (n) begin
         symerr_frame <= 1;
         wt(4);
         symerr_frame <= 0;
         wt(4);
      end
      rd(12'h098, 1);
      rd(12'h0A8, n);
      rd(12'h0A8, 0);
      apb(1, 12'h0D8, 32'hFF00, 4'hF);
      for (int i = 0; i < 8; i++) begin
         event_in[i] <= 1;
         wt(5);
         cmp(port_irq, 1);
         rd(12'h0D8, 32'hFF00 | (1 << i));
         event_in[i] <= 0;
         wt(3);
         cmp(port_irq, 0);
      end
      apb(1, 12'h0D8, 0, 4'hF);
      event_in <= 8'h20;
      wt(6);
      // Source drops again, so only the latch can still show the event
      event_in <= 8'h00;
      wt(24);
      cmp(port_irq, 0);
      rd(12'h0D8, 32'h0020);
      rd(12'h0D8, 0);
      close_out;
   end
endmodule
